// ===== config_segment_protection.sv
`default_nettype none

// Operation
// - Every stored bit reads 0 once programmed and 1 when left erased, and selects its setting.
// - The twelve configuration bytes sit at consecutive even addresses from the base.
// - Configuration space is reached only by table reads and writes, never by other accesses.
// - The remaining reserved power-on bits always read as one.
// - The reserved oscillator-select bit reads back its programmed value.
// - Boot write-protect at 1 permits boot segment writes and at 0 blocks them all.
// - The boot size field gives no segment on 11, else an end by pair, bit 2 picking level.
// - The boot RAM field gives none, 128, 256 or 1024 bytes.
// - Secure write-protect at 1 permits secure segment writes and at 0 blocks them all.
// - On large flash the secure size field ends the segment at 3FFE, 7FFE or FFFE.
// - On small flash the secure size field ends the segment at 1FFE, 3FFE or 7FFE.
// - The secure RAM field gives none, 256, 2048 or 4096 bytes less the boot RAM.
// - The general field gives no protection on 11, standard on 10, high on 0x.
// - Boot follows the vectors, secure follows boot, general runs to end of memory.
module config_segment_protection
  import cfg_prot_pkg::*;
#(
  parameter bit          SMALL_FLASH = 1'b0,
  parameter logic [23:0] VECTOR_END  = 24'h000200,
  parameter logic [23:0] MEM_END     = 24'h03FFFE
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Table access port
  input  wire tbl_req_t   tbl_req,
  output logic [7:0]      tbl_rdata_q,
  output logic            tbl_ack_q,
  output logic            tbl_err_q,
  // Ordinary fetch or data access
  input  wire logic       data_acc_valid,
  input  wire logic [23:0] data_acc_addr,
  output logic            cfg_acc_block_q,
  // Flash write check
  input  wire logic       wr_chk_valid,
  input  wire logic [23:0] wr_chk_addr,
  output logic            wr_chk_done_q,
  output logic            wr_chk_ok_q,
  // Decoded protection map
  output seg_t            boot_seg_q,
  output seg_t            sec_seg_q,
  output seg_t            gen_seg_q,
  output logic [12:0]     boot_ram_bytes_q,
  output logic [12:0]     sec_ram_bytes_q
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (VECTOR_END >= BOOT_END_SMALL) begin : g_bad_vec
    $error("vector space must end below the smallest boot segment end");
  end
  if (MEM_END <= SEC_END_D) begin : g_bad_eom
    $error("end of memory must lie above the largest secure segment end");
  end
  if (VECTOR_END[0] != 1'b0 || MEM_END[0] != 1'b0) begin : g_bad_align
    $error("segment bounds must be even addresses");
  end
  if (MEM_END >= CFG_SPACE_LO) begin : g_bad_top
    $error("end of memory must lie below configuration space");
  end

  logic [7:0]         cfg_q [NUM_CFG];
  logic [NUM_CFG-1:0] hit;
  logic               in_cfg_space;
  logic               tbl_any;
  logic [7:0]         rd_mux;

  assign in_cfg_space = tbl_req.addr >= CFG_SPACE_LO;
  assign tbl_any      = tbl_req.rd | tbl_req.wr;

  // ****************************************
  // Configuration storage
  // ****************************************
  // Reset returns the erased state; a real array keeps it across resets.
  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    assign hit[i] = tbl_req.addr == CFG_OFS[i];
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        cfg_q[i] <= CFG_ERASED;
      end else if (tbl_req.wr && hit[i]) begin
        // Only implemented bits are stored; reserved power-on bits are masked off by CFG_IMPL
        cfg_q[i] <= tbl_req.wdata & CFG_IMPL[i];
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (hit[i]) begin
        // Forced ones cover reserved power-on bits
        rd_mux = (cfg_q[i] & CFG_IMPL[i]) | CFG_ONES[i];
      end
    end
  end

  // ****************************************
  // Table access answer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tbl_ack_q <= 1'b0;
      tbl_err_q <= 1'b0;
    end else begin
      tbl_ack_q <= tbl_any && in_cfg_space;
      tbl_err_q <= tbl_any && in_cfg_space && (hit == '0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tbl_rdata_q <= 8'h00;
    end else if (tbl_req.rd && in_cfg_space) begin
      tbl_rdata_q <= rd_mux;
    end
  end

  // Anything other than a table access is turned away from config space
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_acc_block_q <= 1'b0;
    end else begin
      cfg_acc_block_q <= data_acc_valid && (data_acc_addr >= CFG_SPACE_LO);
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  logic [7:0]  boot_segment_config;
  logic [7:0]  secure_segment_config;
  logic [7:0]  general_segment_config;
  logic [2:0]  bss;
  logic [2:0]  sss;
  logic [1:0]  rbs;
  logic [1:0]  rss;
  logic [1:0]  gss;
  seg_t        boot_d;
  seg_t        sec_d;
  seg_t        gen_d;
  logic [12:0] boot_ram_d;
  logic [12:0] sec_ram_full;
  logic [12:0] sec_ram_d;

  assign boot_segment_config = cfg_q[IDX_BOOT];
  assign secure_segment_config = cfg_q[IDX_SECURE];
  assign general_segment_config = cfg_q[IDX_GENERAL];
  assign bss = boot_segment_config[SIZE_LSB +: 3];
  assign sss = secure_segment_config[SIZE_LSB +: 3];
  assign rbs = boot_segment_config[RAM_LSB +: 2];
  assign rss = secure_segment_config[RAM_LSB +: 2];
  assign gss = general_segment_config[SIZE_LSB +: 2];

  always_comb begin
    boot_d            = '0;
    boot_d.en         = bss[1:0] != 2'b11;
    boot_d.level      = !boot_d.en ? SEC_NONE : (bss[2] ? SEC_STD : SEC_HIGH);
    boot_d.start_addr = VECTOR_END;
    boot_d.wr_en      = boot_segment_config[WRP_BIT];
    case (bss[1:0])
      2'b10:   boot_d.end_addr = BOOT_END_SMALL;
      2'b01:   boot_d.end_addr = BOOT_END_MID;
      2'b00:   boot_d.end_addr = BOOT_END_LARGE;
      default: boot_d.end_addr = VECTOR_END - SEG_STEP;
    endcase
  end

  always_comb begin
    sec_d            = '0;
    sec_d.en         = sss[1:0] != 2'b11;
    sec_d.level      = !sec_d.en ? SEC_NONE : (sss[2] ? SEC_STD : SEC_HIGH);
    // Starts after the boot segment, or after the vectors when there is none
    sec_d.start_addr = boot_d.en ? boot_d.end_addr + SEG_STEP : VECTOR_END;
    sec_d.wr_en      = secure_segment_config[WRP_BIT];
    if (SMALL_FLASH) begin
      case (sss[1:0])
        2'b10:   sec_d.end_addr = SEC_END_A;
        2'b01:   sec_d.end_addr = SEC_END_B;
        2'b00:   sec_d.end_addr = SEC_END_C;
        default: sec_d.end_addr = sec_d.start_addr - SEG_STEP;
      endcase
    end else begin
      case (sss[1:0])
        2'b10:   sec_d.end_addr = SEC_END_B;
        2'b01:   sec_d.end_addr = SEC_END_C;
        2'b00:   sec_d.end_addr = SEC_END_D;
        default: sec_d.end_addr = sec_d.start_addr - SEG_STEP;
      endcase
    end
    // A secure size no larger than boot leaves an empty secure segment
    if (sec_d.en && sec_d.end_addr < sec_d.start_addr) begin
      sec_d.en    = 1'b0;
      sec_d.level = SEC_NONE;
    end
  end

  always_comb begin
    gen_d            = '0;
    gen_d.en         = gss != 2'b11;
    gen_d.level      = !gen_d.en ? SEC_NONE : (gss[1] ? SEC_STD : SEC_HIGH);
    gen_d.start_addr = sec_d.en ? sec_d.end_addr + SEG_STEP :
                       boot_d.en ? boot_d.end_addr + SEG_STEP : VECTOR_END;
    gen_d.end_addr   = MEM_END;
    gen_d.wr_en      = general_segment_config[WRP_BIT];
  end

  always_comb begin
    case (rbs)
      2'b10:   boot_ram_d = BOOT_RAM_S;
      2'b01:   boot_ram_d = BOOT_RAM_M;
      2'b00:   boot_ram_d = BOOT_RAM_L;
      default: boot_ram_d = 13'h0000;
    endcase
    case (rss)
      2'b10:   sec_ram_full = SEC_RAM_S;
      2'b01:   sec_ram_full = SEC_RAM_M;
      2'b00:   sec_ram_full = SEC_RAM_L;
      default: sec_ram_full = 13'h0000;
    endcase
    // Boot RAM comes out of the secure figure; never wraps below zero
    sec_ram_d = (sec_ram_full > boot_ram_d) ? sec_ram_full - boot_ram_d : 13'h0000;
  end

  // ****************************************
  // Registered protection map
  // ****************************************
  // One cycle behind the storage so every output leaves a flip-flop.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boot_seg_q <= '0;
    end else begin
      boot_seg_q <= boot_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sec_seg_q <= '0;
    end else begin
      sec_seg_q <= sec_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gen_seg_q <= '0;
    end else begin
      gen_seg_q <= gen_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boot_ram_bytes_q <= 13'h0000;
    end else begin
      boot_ram_bytes_q <= boot_ram_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sec_ram_bytes_q <= 13'h0000;
    end else begin
      sec_ram_bytes_q <= sec_ram_d;
    end
  end

  // ****************************************
  // Flash write check
  // ****************************************
  function automatic logic in_seg(input seg_t s, input logic [23:0] a);
    in_seg = s.en && a >= s.start_addr && a <= s.end_addr;
  endfunction

  logic wr_in_boot;
  logic wr_in_sec;
  logic wr_in_gen;
  logic wr_blocked;

  assign wr_in_boot = in_seg(boot_d, wr_chk_addr);
  assign wr_in_sec  = in_seg(sec_d, wr_chk_addr);
  // General write-protect covers all of user memory past secure
  assign wr_in_gen  = wr_chk_addr >= gen_d.start_addr && wr_chk_addr <= MEM_END;
  assign wr_blocked = (wr_in_boot && !boot_d.wr_en)
                   || (wr_in_sec && !sec_d.wr_en)
                   || (wr_in_gen && !gen_d.wr_en)
                   || (wr_chk_addr > MEM_END);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_chk_done_q <= 1'b0;
      wr_chk_ok_q   <= 1'b0;
    end else begin
      wr_chk_done_q <= wr_chk_valid;
      wr_chk_ok_q   <= wr_chk_valid && !wr_blocked;
    end
  end

endmodule // config_segment_protection
`default_nettype wire

// ===== cfg_prot_pkg.sv
`default_nettype none
package cfg_prot_pkg;

  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned NUM_CFG = 12;

  // ****************************************
  // Configuration space and byte offsets
  // ****************************************
  localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
  localparam logic [23:0] CFG_OFS [NUM_CFG] = '{
    24'hF80000, 24'hF80002, 24'hF80004, 24'hF80006,
    24'hF80008, 24'hF8000A, 24'hF8000C, 24'hF8000E,
    24'hF80010, 24'hF80012, 24'hF80014, 24'hF80016};
  localparam int unsigned IDX_BOOT    = 0;
  localparam int unsigned IDX_SECURE  = 1;
  localparam int unsigned IDX_GENERAL = 2;

  // ****************************************
  // Read masks: implemented bits, forced ones
  // ****************************************
  localparam logic [7:0] CFG_IMPL [NUM_CFG] = '{
    8'hCF, 8'hCF, 8'h07, 8'hC7, 8'hC7, 8'hFF,
    8'hC7, 8'h23, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] CFG_ONES [NUM_CFG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CFG_ERASED = 8'hFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned WRP_BIT  = 0;
  localparam int unsigned SIZE_LSB = 1;
  localparam int unsigned LVL_BIT  = 3;
  localparam int unsigned RAM_LSB  = 6;

  // ****************************************
  // Segment ends and RAM sizes
  // ****************************************
  localparam logic [23:0] BOOT_END_SMALL = 24'h0007FE;
  localparam logic [23:0] BOOT_END_MID   = 24'h001FFE;
  localparam logic [23:0] BOOT_END_LARGE = 24'h003FFE;
  localparam logic [23:0] SEC_END_A      = 24'h001FFE;
  localparam logic [23:0] SEC_END_B      = 24'h003FFE;
  localparam logic [23:0] SEC_END_C      = 24'h007FFE;
  localparam logic [23:0] SEC_END_D      = 24'h00FFFE;
  localparam logic [23:0] SEG_STEP       = 24'h000002;
  localparam logic [12:0] BOOT_RAM_S     = 13'h0080;
  localparam logic [12:0] BOOT_RAM_M     = 13'h0100;
  localparam logic [12:0] BOOT_RAM_L     = 13'h0400;
  localparam logic [12:0] SEC_RAM_S      = 13'h0100;
  localparam logic [12:0] SEC_RAM_M      = 13'h0800;
  localparam logic [12:0] SEC_RAM_L      = 13'h1000;

  typedef enum logic [1:0] {SEC_NONE, SEC_STD, SEC_HIGH} sec_level_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } tbl_req_t;

  typedef struct packed {
    logic        en;
    sec_level_t  level;
    logic [23:0] start_addr;
    logic [23:0] end_addr;
    logic        wr_en;
  } seg_t;

endpackage
`default_nettype wire

// ===== config_segment_protection_checker.sv
`default_nettype none
module config_segment_protection_checker
  import cfg_prot_pkg::*;
#(
  parameter bit          SMALL_FLASH = 1'b0,
  parameter logic [23:0] VECTOR_END  = 24'h000200,
  parameter logic [23:0] MEM_END     = 24'h03FFFE
) (
  // Clock, reset and table port
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire tbl_req_t    tbl_req,
  input wire logic [7:0]  tbl_rdata_q,
  input wire logic        tbl_ack_q,
  input wire logic        tbl_err_q,
  // Access checks
  input wire logic        data_acc_valid,
  input wire logic [23:0] data_acc_addr,
  input wire logic        cfg_acc_block_q,
  input wire logic        wr_chk_valid,
  input wire logic [23:0] wr_chk_addr,
  input wire logic        wr_chk_done_q,
  input wire logic        wr_chk_ok_q,
  // Decoded map
  input wire seg_t        boot_seg_q,
  input wire seg_t        sec_seg_q,
  input wire seg_t        gen_seg_q,
  input wire logic [12:0] boot_ram_bytes_q,
  input wire logic [12:0] sec_ram_bytes_q
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic tbl_hit;
  assign tbl_hit = (tbl_req.rd || tbl_req.wr) && tbl_req.addr >= CFG_SPACE_LO;
  // Map lags storage by a cycle, so the byte must stay untouched one more cycle
  sequence s_wr_quiet(a, c);
    tbl_req.wr && tbl_req.addr == a && c ##1 !(tbl_req.wr && tbl_req.addr == a);
  endsequence
  property p_ack; tbl_hit |=> tbl_ack_q; endproperty
  property p_no_ack; !tbl_hit |=> !tbl_ack_q && !tbl_err_q; endproperty
  property p_block; data_acc_valid && data_acc_addr >= CFG_SPACE_LO |=> cfg_acc_block_q;
  endproperty
  property p_no_block; !(data_acc_valid && data_acc_addr >= CFG_SPACE_LO) |=> !cfg_acc_block_q;
  endproperty
  property p_done; wr_chk_valid |=> wr_chk_done_q; endproperty
  property p_err; tbl_err_q |-> tbl_ack_q; endproperty
  property p_por; tbl_req.rd && tbl_req.addr == CFG_OFS[6] |=> tbl_rdata_q[5:3] == 3'b111;
  endproperty
  property p_boot_ram;
    s_wr_quiet(CFG_OFS[IDX_BOOT], tbl_req.wdata[7:6] == 2'b10) |=> boot_ram_bytes_q == BOOT_RAM_S;
  endproperty
  property p_boot_none;
    s_wr_quiet(CFG_OFS[IDX_BOOT], tbl_req.wdata[2:1] == 2'b11) |=> !boot_seg_q.en;
  endproperty
  property p_gen_high;
    s_wr_quiet(CFG_OFS[IDX_GENERAL], !tbl_req.wdata[2]) |=> gen_seg_q.level == SEC_HIGH;
  endproperty
  property p_eom; wr_chk_valid && wr_chk_addr > MEM_END |=> wr_chk_done_q && !wr_chk_ok_q;
  endproperty
  property p_ok_done; wr_chk_ok_q |-> wr_chk_done_q; endproperty
  property p_boot_start; boot_seg_q.en |-> boot_seg_q.start_addr == VECTOR_END; endproperty
  a_ack: assert property (p_ack) else $error("table access not answered");
  a_no_ack: assert property (p_no_ack) else $error("spurious table answer");
  a_block: assert property (p_block) else $error("config access not refused");
  a_no_block: assert property (p_no_block) else $error("spurious refusal");
  a_done: assert property (p_done) else $error("write check not done");
  a_err: assert property (p_err) else $error("error without answer");
  a_por: assert property (p_por) else $error("power-on reserved bits not one");
  a_boot_ram: assert property (p_boot_ram) else $error("boot ram size wrong");
  a_boot_none: assert property (p_boot_none) else $error("boot segment present");
  a_gen_high: assert property (p_gen_high) else $error("general level wrong");
  a_eom: assert property (p_eom) else $error("write past end of memory allowed");
  a_ok_done: assert property (p_ok_done) else $error("write allowed without done");
  a_boot_start: assert property (p_boot_start) else $error("boot start wrong");
endmodule // config_segment_protection_checker
bind config_segment_protection config_segment_protection_checker #(.SMALL_FLASH(SMALL_FLASH),
  .VECTOR_END(VECTOR_END), .MEM_END(MEM_END)) chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .tbl_req(tbl_req), .tbl_rdata_q(tbl_rdata_q), .tbl_ack_q(tbl_ack_q), .tbl_err_q(tbl_err_q),
  .data_acc_valid(data_acc_valid), .data_acc_addr(data_acc_addr),
  .cfg_acc_block_q(cfg_acc_block_q), .wr_chk_valid(wr_chk_valid), .wr_chk_addr(wr_chk_addr),
  .wr_chk_done_q(wr_chk_done_q), .wr_chk_ok_q(wr_chk_ok_q), .boot_seg_q(boot_seg_q),
  .sec_seg_q(sec_seg_q), .gen_seg_q(gen_seg_q), .boot_ram_bytes_q(boot_ram_bytes_q),
  .sec_ram_bytes_q(sec_ram_bytes_q));
`default_nettype wire

// ===== config_segment_protection_test.sv
`default_nettype none
module config_segment_protection_test import cfg_prot_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] VEC  = 24'h000200;
  localparam logic [23:0] MEND = 24'h03FFFE;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  tbl_req_t    tbl_req = '0;
  logic        dv = 1'b0, wv = 1'b0, ack, err, blk, done, ok, ben, sen, sen2;
  logic [23:0] da = '0, wa = '0, bend, send, ssta, gsta, send2;
  logic [7:0]  rdata, d;
  logic [7:0]  mdl [NUM_CFG];
  logic [2:0]  bc, sc;
  logic [1:0]  bi, si;
  logic [12:0] rb [4] = '{BOOT_RAM_L, BOOT_RAM_M, BOOT_RAM_S, 13'h0000};
  logic [12:0] sr [4] = '{SEC_RAM_L, SEC_RAM_M, SEC_RAM_S, 13'h0000};
  seg_t        bs, ss, gs, ss2;
  logic [12:0] brb, srb;
  int          errors = 0, comparisons = 0;
  config_segment_protection #(.SMALL_FLASH(1'b0), .VECTOR_END(VEC), .MEM_END(MEND)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tbl_req(tbl_req), .tbl_rdata_q(rdata),
    .tbl_ack_q(ack), .tbl_err_q(err), .data_acc_valid(dv), .data_acc_addr(da),
    .cfg_acc_block_q(blk), .wr_chk_valid(wv), .wr_chk_addr(wa), .wr_chk_done_q(done),
    .wr_chk_ok_q(ok), .boot_seg_q(bs), .sec_seg_q(ss), .gen_seg_q(gs),
    .boot_ram_bytes_q(brb), .sec_ram_bytes_q(srb));
  // Small-flash twin shares all inputs; only its secure map is compared
  config_segment_protection #(.SMALL_FLASH(1'b1), .VECTOR_END(VEC), .MEM_END(MEND)) small_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tbl_req(tbl_req), .tbl_rdata_q(), .tbl_ack_q(),
    .tbl_err_q(), .data_acc_valid(dv), .data_acc_addr(da), .cfg_acc_block_q(),
    .wr_chk_valid(wv), .wr_chk_addr(wa), .wr_chk_done_q(), .wr_chk_ok_q(),
    .boot_seg_q(), .sec_seg_q(ss2), .gen_seg_q(), .boot_ram_bytes_q(), .sec_ram_bytes_q());
  // ****************************************
  // Bus tasks and model
  // ****************************************
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tbl(logic r, logic w, logic [23:0] a, logic [7:0] wd);
    int i;
    logic hit;
    i = 0;
    hit = 1'b0;
    for (int k = 0; k < NUM_CFG; k++) if (a == CFG_OFS[k]) begin
      hit = 1'b1;
      i = k;
    end
    @(posedge sys_clk);
    tbl_req <= '{r, w, a, wd};
    @(posedge sys_clk);
    tbl_req <= '0;
    #1;
    check("ack", a >= CFG_SPACE_LO, ack);
    check("err", a >= CFG_SPACE_LO && !hit, err);
    if (r && a >= CFG_SPACE_LO) check("rdata", hit ? mdl[i] & CFG_IMPL[i] | CFG_ONES[i] : 0, rdata);
    if (w && hit) mdl[i] = wd;
  endtask
  task automatic acc(logic [23:0] a, logic c, logic e);
    @(posedge sys_clk);
    if (c) wv <= 1'b1; else dv <= 1'b1;
    da <= a;
    wa <= a;
    @(posedge sys_clk);
    {dv, wv} <= 2'b00;
    #1;
    if (c) check("wr_ok", {1'b1, e}, {done, ok});
    else check("block", a >= CFG_SPACE_LO, blk);
  endtask
  task automatic pulse_reset;
    sys_rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (mdl[i]) mdl[i] = 8'hFF;
    @(posedge sys_clk);
    #1;
    check("erased", {bs.en, ss.en, gs.level, bs.wr_en, ss.wr_en, gs.wr_en},
          {2'b00, SEC_NONE, 3'b111});
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    conclude();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h7C5D));
    pulse_reset();
    for (int i = 0; i < NUM_CFG; i++) tbl(1'b1, 1'b0, CFG_OFS[i], 8'h00);
    for (int i = 0; i < NUM_CFG; i++) begin
      d = 8'($urandom);
      if (i == 6) d[7:6] = 2'b11;
      tbl(1'b1, 1'b1, CFG_OFS[i], d);
      tbl(1'b1, 1'b0, CFG_OFS[i], 8'h00);
    end
    tbl(1'b1, 1'b1, 24'hF80001, 8'h00);
    tbl(1'b1, 1'b0, 24'hF80018, 8'h00);
    tbl(1'b1, 1'b1, 24'h7FFFFE, 8'h00);
    acc(24'h7FFFFF, 1'b0, 1'b0);
    acc(CFG_SPACE_LO, 1'b0, 1'b0);
    acc(24'($urandom), 1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      bc = k[2:0];
      sc = ~bc;
      bi = k[1:0];
      si = k[2:1];
      tbl(1'b0, 1'b1, CFG_OFS[0], {bi, 2'b11, bc, k[2]});
      tbl(1'b0, 1'b1, CFG_OFS[1], {si, 2'b11, sc, !k[1]});
      tbl(1'b0, 1'b1, CFG_OFS[2], {5'h00, bi, k != 5});
      @(posedge sys_clk);
      #1;
      ben = bc[1:0] != 2'b11;
      bend = bc[1:0] == 2'b10 ? BOOT_END_SMALL : bc[1:0] == 2'b01 ? BOOT_END_MID : BOOT_END_LARGE;
      ssta = ben ? bend + 24'h2 : VEC;
      send = sc[1:0] == 2'b10 ? SEC_END_B : sc[1:0] == 2'b01 ? SEC_END_C : SEC_END_D;
      sen = sc[1:0] != 2'b11 && send >= ssta;
      gsta = sen ? send + 24'h2 : ssta;
      check("boot_en", ben, bs.en);
      if (ben) check("boot_seg", {bc[2] ? SEC_STD : SEC_HIGH, bend}, {bs.level, bs.end_addr});
      if (ben) check("boot_start", VEC, bs.start_addr);
      check("boot_ram", rb[bi], brb);
      check("sec_en", sen, ss.en);
      if (sen) check("sec_seg", {sc[2] ? SEC_STD : SEC_HIGH, send}, {ss.level, ss.end_addr});
      if (sen) check("sec_start", ssta, ss.start_addr);
      send2 = sc[1:0] == 2'b10 ? SEC_END_A : sc[1:0] == 2'b01 ? SEC_END_B : SEC_END_C;
      sen2 = sc[1:0] != 2'b11 && send2 >= ssta;
      check("small_sec_en", sen2, ss2.en);
      if (sen2) check("small_sec", {sc[2] ? SEC_STD : SEC_HIGH, send2}, {ss2.level, ss2.end_addr});
      check("sec_ram", si == 3 || sr[si] <= rb[bi] ? 13'h0 : sr[si] - rb[bi], srb);
      check("gen_lvl", bi == 3 ? SEC_NONE : bi == 2 ? SEC_STD : SEC_HIGH, gs.level);
      check("gen_start", gsta, gs.start_addr);
      acc(VEC, 1'b1, ben ? k[2] : sen ? !k[1] : k != 5);
      acc(MEND, 1'b1, k != 5);
      acc(MEND + 24'h2, 1'b1, 1'b0);
    end
    // Reset mid-run must bring every byte back to the erased state
    @(posedge sys_clk);
    pulse_reset();
    for (int i = 0; i < NUM_CFG; i++) tbl(1'b1, 1'b0, CFG_OFS[i], 8'h00);
    conclude();
  end
endmodule // config_segment_protection_test
`default_nettype wire
